//--- verification/knx_far_end.sv
/*
  Far-end bus device: takes setpoint and shift telegrams from the block.
  Assumes one-cycle send pulses qualified by the value ports.
*/
`timescale 1ns/1ps
module knx_far_end (
  input wire pclk,
  input wire setpoint_tx,
  input wire [15:0] setpoint_value,
  input wire shift_tx,
  input wire [7:0] shift_value
);
  // Counts survive a device reset, as a real listener would
  int tx_count = 0;
  logic [15:0] last_set = 16'h0000;
  logic [7:0] ext_shift = 8'h00;
  always @(posedge pclk) begin
    if (setpoint_tx === 1'b1) begin
      tx_count <= tx_count + 1;
      last_set <= setpoint_value;
    end
    // Extension copies the step count only on a shift send; a clear without a send leaves the old count
    if (shift_tx === 1'b1) ext_shift <= shift_value;
  end
endmodule // knx_far_end

//--- verification/setpoint_asserts.sv
/*
  Checker for the setpoint block, watching only the top-level ports.
  Assumes the single clock pclk and the active-low asynchronous reset presetn.
*/
`timescale 1ns/1ps
`include "setpoint_defines.vh"
module setpoint_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire setpoint_tx,
  input wire [15:0] setpoint_value,
  input wire shift_tx,
  input wire [7:0] shift_value,
  input wire nvm_write
);
  // ****************************************
  // Bus and telegram relations
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  a_ready_follows: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_idle: assert property (!setup |=> !pready)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (setup && (paddr > `A_OBJSET || paddr[1:0] != 2'b00)
    |=> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (setup && paddr <= `A_OBJSET && paddr[1:0] == 2'b00
    |=> !pslverr)
    else $error("mapped access flagged");
  a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_startup_send: assert property ($rose(presetn) |-> ##[1:3] setpoint_tx)
    else $error("no send after reset");
  a_value_with_tx: assert property ($changed(setpoint_value) |-> setpoint_tx)
    else $error("setpoint value moved without a send");
  a_tx_one_cycle: assert property (setpoint_tx |=> !setpoint_tx)
    else $error("setpoint send longer than one cycle");
  a_nvm_one_cycle: assert property (nvm_write |=> !nvm_write)
    else $error("store write longer than one cycle");
  a_step_feedback: assert property (setup && pwrite && paddr == `A_STEP
    |-> ##[1:3] shift_tx)
    else $error("step without shift feedback");
endmodule // setpoint_asserts
bind setpoint_shift_store_transmit setpoint_asserts setpoint_asserts_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .setpoint_tx(setpoint_tx), .setpoint_value(setpoint_value), .shift_tx(shift_tx),
  .shift_value(shift_value), .nvm_write(nvm_write));

//--- verification/setpoint_shift_store_transmit_test.sv
/*
  Self-checking bench for the setpoint block, with an APB master and a far-end model.
  Assumes a shortened minute of 16 cycles; temperatures in 0.1 K units.
*/
`timescale 1ns/1ps
`include "setpoint_defines.vh"
module setpoint_shift_store_transmit_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, setpoint_tx, shift_tx, nvm_write, perr;
  logic [15:0] setpoint_value;
  logic [7:0] shift_value;
  int err_count = 0, total_checks = 0, nvm_count = 0, c;
  setpoint_shift_store_transmit #(.minute_cycles(34'h10)) setpoint_shift_store_transmit_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setpoint_tx(setpoint_tx), .setpoint_value(setpoint_value), .shift_tx(shift_tx),
    .shift_value(shift_value), .nvm_write(nvm_write));
  knx_far_end knx_far_end_i (.pclk(pclk), .setpoint_tx(setpoint_tx),
    .setpoint_value(setpoint_value), .shift_tx(shift_tx), .shift_value(shift_value));
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) if (nvm_write === 1'b1) nvm_count <= nvm_count + 1;
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered just after a rising edge; ends one idle cycle after release
  // Waits for pready with no cycle limit; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    repeat (2) @(posedge pclk);
    apb(1'b0, a, 32'h00000000);
    chk(n, e, rd);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset;
    rdc("basic", `A_BASIC, 32'h000000d2);
    rdc("frost", `A_FROST, 32'h00000046);
    rdc("active", `A_ACTIVE, 32'h000000c8);
    rdc("comfort", `A_COMFORT, 32'h00dc00c8);
    chk("startup count", 32'h1, knx_far_end_i.tx_count);
    chk("startup value", 32'hc8, knx_far_end_i.last_set);
    rdc("object", `A_OBJSET, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk("slverr", 32'h1, perr);
    chk("unmapped", 32'h0, rd);
  endtask
  task automatic s_shift;
    wr(`A_CTRL, 32'h8);
    wr(`A_RXSHIFT, 32'd100);
    rdc("clamp up", `A_RXSHIFT, 32'h1c);
    chk("feedback", 32'h1c, shift_value);
    chk("extension", 32'h1c, knx_far_end_i.ext_shift);
    wr(`A_RXSHIFT, 32'h80);
    rdc("clamp down", `A_RXSHIFT, 32'he4);
    wr(`A_RXSHIFT, 32'h2);
    rdc("jump", `A_RXSHIFT, 32'h2);
    rdc("shifted", `A_ACTIVE, 32'hd2);
    wr(`A_STEP, 32'h1);
    rdc("up", `A_RXSHIFT, 32'h3);
    wr(`A_STEP, 32'h2);
    wr(`A_STEP, 32'h2);
    rdc("down", `A_RXSHIFT, 32'h1);
    rdc("heat", `A_HEAT, 32'h15e);
    wr(`A_EVENT, 32'h1);
    rdc("mode clear", `A_RXSHIFT, 32'h0);
    wr(`A_RXSHIFT, 32'h3);
    wr(`A_RXSET, 32'hd2);
    rdc("basic clear", `A_RXSHIFT, 32'h0);
    wr(`A_CTRL, 32'hc);
    wr(`A_RXSHIFT, 32'h2);
    wr(`A_EVENT, 32'h2);
    wr(`A_RXSET, 32'hd2);
    rdc("persist", `A_RXSHIFT, 32'h2);
    wr(`A_EVENT, 32'h4);
    rdc("restart", `A_RXSHIFT, 32'h0);
    chk("feedback clear", 32'h0, shift_value);
  endtask
  task automatic s_absolute;
    wr(`A_CTRL, 32'h1);
    wr(`A_RXSHIFT, 32'h5);
    rdc("abs refuse", `A_RXSHIFT, 32'h0);
    wr(`A_CTRL, 32'h21);
    c = knx_far_end_i.tx_count;
    wr(`A_RXSET, 32'hc3);
    repeat (4) @(posedge pclk);
    chk("abs echo", c + 1, knx_far_end_i.tx_count);
    chk("abs echo value", 32'hc3, knx_far_end_i.last_set);
    wr(`A_CTRL, 32'h20);
    c = knx_far_end_i.tx_count;
    wr(`A_RXSET, 32'hc8);
    repeat (4) @(posedge pclk);
    chk("no basic echo", c, knx_far_end_i.tx_count);
  endtask
  task automatic s_store;
    wr(`A_CTRL, 32'h2);
    c = nvm_count;
    wr(`A_RXSET, 32'he6);
    repeat (3) @(posedge pclk);
    chk("store", c + 1, nvm_count);
    rdc("object", `A_OBJSET, 32'he6);
    c = knx_far_end_i.tx_count;
    wr(`A_EVENT, 32'h4);
    rdc("object gone", `A_OBJSET, 32'h0);
    rdc("kept", `A_ACTIVE, 32'hdc);
    chk("resend", c + 1, knx_far_end_i.tx_count);
    chk("resend value", 32'hdc, knx_far_end_i.last_set);
  endtask
  task automatic s_temp;
    wr(`A_CTRL, 32'h0);
    c = nvm_count;
    wr(`A_RXSET, 32'hf0);
    rdc("temp", `A_ACTIVE, 32'he6);
    chk("no store", c, nvm_count);
    wr(`A_EVENT, 32'h1);
    rdc("dropped", `A_ACTIVE, 32'hdc);
  endtask
  task automatic s_send;
    wr(`A_TXCFG, 32'h0);
    c = knx_far_end_i.tx_count;
    wr(`A_RXSET, 32'hfa);
    repeat (40) @(posedge pclk);
    chk("silent", c, knx_far_end_i.tx_count);
    wr(`A_TXCFG, 32'h5);
    repeat (4) @(posedge pclk);
    c = knx_far_end_i.tx_count;
    wr(`A_RXSET, 32'hfd);
    repeat (4) @(posedge pclk);
    chk("small", c, knx_far_end_i.tx_count);
    wr(`A_RXSET, 32'h104);
    repeat (4) @(posedge pclk);
    chk("delta", c + 1, knx_far_end_i.tx_count);
    chk("delta value", 32'hfa, knx_far_end_i.last_set);
    wr(`A_TXCFG, 32'h100);
    c = knx_far_end_i.tx_count;
    repeat (40) @(posedge pclk);
    chk("cyclic", 32'h1, (knx_far_end_i.tx_count - c) inside {2, 3});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_shift();
    s_absolute();
    s_store();
    s_temp();
    s_send();
    report_and_stop();
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule // setpoint_shift_store_transmit_test

//--- verilog/setpoint_defines.vh
// Overview of operation
// - Permanent acceptance writes a received setpoint into the non-volatile store
// - Stored values survive restart, mode and heat/cool change; absolute kept per slot
// - Relative mode never reports the shifted basic setpoint back onto the bus
// - Absolute mode may send the resulting setpoint when transmit is permitted
// - Temporary acceptance drops the value on restart, mode or heat/cool switch
// - After restart with permanent acceptance objects stay empty until a telegram
// - Relative mode keeps the deadband in the non-volatile store always; here it sits only in the deadband register, which presetn resets
// - Shift step width is selectable as 0.1 K or 0.5 K
// - Every shift request is refused under absolute presetting
// - Shift offsets basic setpoint; limited by heat above and frost below
// - Without persistence the shift clears on mode, heat/cool or basic change
// - With persistence the shift survives mode, heat/cool and basic changes
// - Shift lives in volatile storage only and clears on any restart
// - Frost and heat protection setpoints never move with the shift
// - A one-byte signed shift request jumps straight to that step count
// - A request beyond a limit is clamped and the feedback shows the limit
// - Shift counter counts up per positive step, down per negative step
// - Send setpoint once it moved by the set delta; zero disables
// - Send setpoint every 1 to 255 minutes; zero disables
// - After restart or reprogramming load and send the current setpoint
// - Relative comfort heat and cool derive from basic setpoint and deadband
/*
  Register offsets, field positions and timing constants of the setpoint block.
  Temperatures are signed 16-bit values in 0.1 K units. Assumes a 200 MHz pclk.
*/
`ifndef SETPOINT_DEFINES_VH
`define SETPOINT_DEFINES_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define A_CTRL 12'h000
`define A_BASIC 12'h004
`define A_FROST 12'h008
`define A_HEAT 12'h00c
`define A_DEADBAND 12'h010
`define A_TXCFG 12'h014
`define A_EVENT 12'h018
`define A_RXSET 12'h01c
`define A_RXSHIFT 12'h020
`define A_STEP 12'h024
`define A_STATUS 12'h028
`define A_ACTIVE 12'h02c
`define A_COMFORT 12'h030
`define A_OBJSET 12'h034
// ****************************************
// Field positions
// ****************************************
`define C_ABS 0
`define C_PERM 1
`define C_PERSIST 2
`define C_HALF 3
`define C_ASYM 4
`define C_TXPERMIT 5
`define E_MODE 0
`define E_HC 1
`define E_RESTART 2
`define E_REPROG 3
`define E_MODE_LO 4
`define E_MODE_HI 5
`define E_HCVAL 6
`define S_UP 0
`define S_DOWN 1
// ****************************************
// Reset values and constants
// ****************************************
`define R_CTRL 8'h00
`define R_BASIC 16'h00d2
`define R_FROST 16'h0046
`define R_HEAT 16'h015e
`define R_DEADBAND 16'h0014
`define STEP_FINE 16'h0001
`define STEP_HALF 16'h0005
`define DIV5_MUL 32'h000000cd
`define LIM_POS 16'h007f
`define LIM_NEG 16'h0080
`define MINUTE_S 64'h000000000000003c
`define CLK_HZ 64'h000000000bebc200
`endif

//--- verilog/setpoint_shift_store_transmit.v
/*
  Setpoint store, basic setpoint shift and setpoint transmission, as an APB slave.
  Assumes telegram reception is decoded elsewhere and written into the RX registers,
  and that the setpoint output pulse is turned into a bus telegram elsewhere.
*/
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "setpoint_defines.vh"
module setpoint_shift_store_transmit #(
  parameter [33:0] minute_cycles = 34'h2cb417800
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg setpoint_tx,
  output reg [15:0] setpoint_value,
  output reg shift_tx,
  output reg [7:0] shift_value,
  output reg nvm_write
);
  // ****************************************
  // Configuration and state
  // ****************************************
  reg [7:0] ctrl;
  reg [15:0] cfg_basic;
  reg [15:0] frost;
  reg [15:0] heat;
  reg [15:0] deadband;
  reg [15:0] txcfg;
  reg [1:0] mode;
  reg hc;
  reg [15:0] nv_basic;
  reg nv_ok;
  reg [15:0] nv_abs [0:7];
  reg [7:0] nv_abs_ok;
  reg [15:0] tmp_val;
  reg tmp_ok;
  reg obj_valid;
  reg [7:0] shift;
  reg [15:0] last_sent;
  reg [33:0] min_cnt;
  reg [7:0] cyc_cnt;
  reg tx_req;
  integer i;

  wire is_abs = ctrl[`C_ABS];
  wire perm = ctrl[`C_PERM];
  wire persist = ctrl[`C_PERSIST];
  wire half = ctrl[`C_HALF];
  wire [2:0] slot = {mode, hc};

  // ****************************************
  // Setpoint derivation
  // ****************************************
  // Initial value unless a telegram replaced it, permanently or for now
  // A stored value replaces the configured one, so a dropped temporary value
  // falls back to whatever the store holds
  wire [15:0] rel_init = nv_ok ? nv_basic : cfg_basic;
  wire [15:0] abs_init = nv_abs_ok[slot] ? nv_abs[slot] : cfg_basic;
  wire [15:0] rel_src = perm ? rel_init :
    (tmp_ok ? tmp_val : rel_init);
  wire [15:0] abs_src = perm ? abs_init :
    (tmp_ok ? tmp_val : abs_init);
  wire [15:0] shift_x = {{8{shift[7]}}, shift};
  wire [15:0] step_w = half ? `STEP_HALF : `STEP_FINE;
  // Low half of the product is the signed offset in 0.1 K units
  wire [31:0] shift_p = shift_x * step_w;
  wire [15:0] shift_k = shift_p[15:0];
  wire [15:0] eff_basic = rel_src + shift_k;
  wire [15:0] db_half = {deadband[15], deadband[15:1]};
  wire [15:0] comf_heat = ctrl[`C_ASYM] ? eff_basic : eff_basic - db_half;
  wire [15:0] comf_cool = ctrl[`C_ASYM] ? eff_basic + deadband :
    eff_basic + db_half;
  wire [15:0] active = is_abs ? abs_src : (hc ? comf_cool : comf_heat);

  // ****************************************
  // Shift limits
  // ****************************************
  // Limits are measured from the unshifted basic; protection values stay put
  wire [15:0] head_up = heat - rel_src;
  wire [15:0] head_dn = rel_src - frost;
  wire [15:0] lim_up;
  wire [15:0] lim_dn;
  shift_limit #(
    .cap(`LIM_POS)
  ) shift_limit_up (
    .headroom(head_up),
    .half(half),
    .limit(lim_up)
  );
  shift_limit #(
    .cap(`LIM_NEG)
  ) shift_limit_dn (
    .headroom(head_dn),
    .half(half),
    .limit(lim_dn)
  );
  wire [15:0] neg_dn = 16'h0000 - lim_dn;

  // ****************************************
  // APB access decode
  // ****************************************
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire w_ctrl = wr & (paddr == `A_CTRL);
  wire w_basic = wr & (paddr == `A_BASIC);
  wire w_frost = wr & (paddr == `A_FROST);
  wire w_heat = wr & (paddr == `A_HEAT);
  wire w_deadband = wr & (paddr == `A_DEADBAND);
  wire w_txcfg = wr & (paddr == `A_TXCFG);
  wire w_event = wr & (paddr == `A_EVENT);
  wire w_rxset = wr & (paddr == `A_RXSET);
  wire w_rxshift = wr & (paddr == `A_RXSHIFT);
  wire w_step = wr & (paddr == `A_STEP);
  wire ev_mode = w_event & pwdata[`E_MODE];
  wire ev_hc = w_event & pwdata[`E_HC];
  wire ev_restart = w_event & pwdata[`E_RESTART];
  wire ev_reprog = w_event & pwdata[`E_REPROG];
  wire [15:0] rx_val = pwdata[15:0];
  wire [15:0] rq_x = {{8{pwdata[7]}}, pwdata[7:0]};

  reg mapped;
  reg [31:0] rdata;
  always @* begin
    mapped = 1'b1;
    rdata = 32'h00000000;
    case (paddr)
      `A_CTRL: rdata = {24'h000000, ctrl};
      `A_BASIC: rdata = {16'h0000, cfg_basic};
      `A_FROST: rdata = {16'h0000, frost};
      `A_HEAT: rdata = {16'h0000, heat};
      `A_DEADBAND: rdata = {16'h0000, deadband};
      `A_TXCFG: rdata = {16'h0000, txcfg};
      `A_EVENT: rdata = {25'h0000000, hc, mode, 4'h0};
      `A_RXSET: rdata = 32'h00000000;
      `A_RXSHIFT: rdata = {24'h000000, shift};
      `A_STEP: rdata = 32'h00000000;
      `A_STATUS: rdata = {lim_dn[7:0], lim_up[7:0], 5'h00, obj_valid, tmp_ok, nv_ok,
        shift};
      `A_ACTIVE: rdata = {16'h0000, active};
      `A_COMFORT: rdata = {comf_cool, comf_heat};
      // Object view stays empty until a telegram was accepted after restart
      `A_OBJSET: rdata = obj_valid ? {16'h0000, is_abs ? abs_src : rel_src} :
        32'h00000000;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states: pready rises in the access phase of every transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h00000000 : rdata;
        pslverr <= ~mapped;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Deadband is configuration and never cleared by a bus restart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `R_CTRL;
      cfg_basic <= `R_BASIC;
      frost <= `R_FROST;
      heat <= `R_HEAT;
      deadband <= `R_DEADBAND;
      txcfg <= 16'h0000;
      mode <= 2'b00;
      hc <= 1'b0;
    end else begin
      if (w_ctrl)
        ctrl <= pwdata[7:0];
      if (w_basic)
        cfg_basic <= pwdata[15:0];
      if (w_frost)
        frost <= pwdata[15:0];
      if (w_heat)
        heat <= pwdata[15:0];
      if (w_deadband)
        deadband <= pwdata[15:0];
      if (w_txcfg)
        txcfg <= pwdata[15:0];
      // Mode and heating/cooling move only by event writes; they pick slot and side
      if (ev_mode)
        mode <= pwdata[`E_MODE_HI:`E_MODE_LO];
      if (ev_hc)
        hc <= pwdata[`E_HCVAL];
    end
  end

  // ****************************************
  // Setpoint store
  // ****************************************
  // The non-volatile copy is only lost on a hard reset, never on a bus restart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_basic <= 16'h0000;
      nv_ok <= 1'b0;
      nv_abs_ok <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
        nv_abs[i] <= 16'h0000;
      tmp_val <= 16'h0000;
      tmp_ok <= 1'b0;
      obj_valid <= 1'b0;
      nvm_write <= 1'b0;
    end else begin
      nvm_write <= 1'b0;
      if (ev_restart | ev_reprog) begin
        tmp_ok <= 1'b0;
        obj_valid <= 1'b0;
      end else if (w_rxset) begin
        obj_valid <= 1'b1;
        if (perm) begin
          // Each pulse is one write to a store of limited endurance
          nvm_write <= 1'b1;
          // Absolute values keep one slot per operating mode and heating/cooling
          if (is_abs) begin
            nv_abs[slot] <= rx_val;
            nv_abs_ok[slot] <= 1'b1;
          end else begin
            nv_basic <= rx_val;
            nv_ok <= 1'b1;
          end
        end else begin
          tmp_val <= rx_val;
          tmp_ok <= 1'b1;
        end
      end else if (ev_mode | ev_hc)
        tmp_ok <= 1'b0;
    end
  end

  // ****************************************
  // Basic setpoint shift
  // ****************************************
  // Kept only in flops: any restart starts from no shift
  wire basic_change = w_rxset & ~is_abs;
  wire [15:0] up1 = shift_x + 16'h0001;
  wire [15:0] dn1 = shift_x - 16'h0001;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift <= 8'h00;
      shift_tx <= 1'b0;
      shift_value <= 8'h00;
    end else begin
      shift_tx <= 1'b0;
      // Feedback object follows every clear so it never shows a stale count
      if (ev_restart | ev_reprog) begin
        shift <= 8'h00;
        shift_value <= 8'h00;
      end else if (is_abs) begin
        shift <= 8'h00;
        shift_value <= 8'h00;
      end else if ((ev_mode | ev_hc | basic_change) & ~persist) begin
        shift <= 8'h00;
        shift_value <= 8'h00;
      end else if (w_rxshift) begin
        shift_tx <= 1'b1;
        if ($signed(rq_x) > $signed(lim_up)) begin
          shift <= lim_up[7:0];
          shift_value <= lim_up[7:0];
        end else if ($signed(rq_x) < $signed(neg_dn)) begin
          shift <= neg_dn[7:0];
          shift_value <= neg_dn[7:0];
        end else begin
          shift <= pwdata[7:0];
          shift_value <= pwdata[7:0];
        end
        // Steps past a limit are dropped; only received jumps are clamped
      end else if (w_step & pwdata[`S_UP]) begin
        if ($signed(up1) <= $signed(lim_up)) begin
          shift <= up1[7:0];
          shift_value <= up1[7:0];
          shift_tx <= 1'b1;
        end
      end else if (w_step & pwdata[`S_DOWN]) begin
        if ($signed(dn1) >= $signed(neg_dn)) begin
          shift <= dn1[7:0];
          shift_value <= dn1[7:0];
          shift_tx <= 1'b1;
        end
      end
      // With persistence none of the clears above fire on mode or basic change
    end
  end

  // ****************************************
  // Setpoint transmission
  // ****************************************
  // One minute is far beyond 2^32 cycles at this rate, hence 34 bits
  wire [63:0] minute_full = `MINUTE_S * `CLK_HZ;
  wire [33:0] minute_len = (minute_cycles == 34'h000000000) ? minute_full[33:0] :
    minute_cycles;
  wire minute_tick = (min_cnt >= minute_len - 34'h000000001);
  wire [7:0] tx_delta = txcfg[7:0];
  wire [7:0] tx_period = txcfg[15:8];
  // Delta is taken against the value last sent, so slow drift still ends in a send
  wire [15:0] diff = active - last_sent;
  wire [15:0] mag = diff[15] ? (16'h0000 - diff) : diff;
  wire delta_hit = (tx_delta != 8'h00) & (mag >= {8'h00, tx_delta});
  wire cyc_hit = (tx_period != 8'h00) & minute_tick &
    (cyc_cnt + 8'h01 >= tx_period);
  // Only the active setpoint goes out; the shifted basic is never echoed
  wire abs_echo = w_rxset & is_abs & ctrl[`C_TXPERMIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_cnt <= 34'h000000000;
      cyc_cnt <= 8'h00;
      tx_req <= 1'b1;
      setpoint_tx <= 1'b0;
      setpoint_value <= 16'h0000;
      last_sent <= 16'h0000;
    end else begin
      setpoint_tx <= 1'b0;
      if (minute_tick)
        min_cnt <= 34'h000000000;
      else
        min_cnt <= min_cnt + 34'h000000001;
      // Cycle counter rests at zero while periodic sending is off
      if (cyc_hit | (tx_period == 8'h00))
        cyc_cnt <= 8'h00;
      else if (minute_tick)
        cyc_cnt <= cyc_cnt + 8'h01;
      // A request waits one cycle so the send carries the value the event produced
      if (ev_restart | ev_reprog | abs_echo)
        tx_req <= 1'b1;
      else if (tx_req | delta_hit | cyc_hit) begin
        tx_req <= 1'b0;
        setpoint_tx <= 1'b1;
        setpoint_value <= active;
        last_sent <= active;
      end
    end
  end
endmodule // setpoint_shift_store_transmit

// ****************************************
// Shift limit in steps
// ****************************************
// Turns protection headroom into a step count, capped at the byte range
module shift_limit #(
  parameter [15:0] cap = `LIM_POS
) (
  input wire [15:0] headroom,
  input wire half,
  output wire [15:0] limit
);
  // Division by five by multiply and shift; exact while the headroom stays
  // below 102.4 K, which the protection range never exceeds.
  wire [31:0] prod = {16'h0000, headroom} * `DIV5_MUL;
  // A protection value on the wrong side of the basic leaves no headroom
  wire none_left = headroom[15] | (headroom == 16'h0000);
  wire [15:0] raw = none_left ? 16'h0000 : (half ? prod[25:10] : headroom);
  assign limit = (raw > cap) ? cap : raw;
endmodule // shift_limit
